// >>> logic/fault_flag_status_bank.sv
`timescale 1ns/100ps
`default_nettype none
module fault_flag_status_bank
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fault detectors from the converter core (same clock)
   input wire logic pos_input_range_fault,
   input wire logic neg_input_range_fault,
   input wire logic reference_range_fault,
   input wire logic reference_low_fault,
   input wire logic result_clamp_fault,
   input wire logic calibration_range_fault,
   input wire logic modulator_saturation,
   input wire logic access_while_ignored,
   // serial frame monitoring, from the serial port logic (same clock)
   input wire logic frame_active,
   input wire logic frame_clock_edge,
   // enable register contents
   input wire logic [15:0] fault_enable,
   // register access from the serial port
   input wire logic status_write,
   input wire logic [15:0] status_wdata,
   // status register contents
   output logic [15:0] fault_status_flags
);
   typedef struct packed
   {
      logic [15:0] flags;
   } bank_state_t;

   bank_state_t st_ff;
   bank_state_t nxt_st;
   logic count_fault;
   logic [15:0] raw_events;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;

   // ----------------------------------------
   // frame clock counter
   // ----------------------------------------
   frame_edge_checker u_edge_chk
   (
      .clk(clk),
      .reset(reset),
      .frame_active(frame_active),
      .clock_edge(frame_clock_edge),
      .count_fault(count_fault)
   );

   // ----------------------------------------
   // event gathering
   // ----------------------------------------
   always_comb
   begin
      raw_events = 16'h0000;
      raw_events[fault_flag_pkg::bit_pos_input] = pos_input_range_fault; // R01
      raw_events[fault_flag_pkg::bit_neg_input] = neg_input_range_fault; // R02
      raw_events[fault_flag_pkg::bit_ref_range] = reference_range_fault; // R03
      raw_events[fault_flag_pkg::bit_ref_detect] = reference_low_fault; // R04
      raw_events[fault_flag_pkg::bit_converter] = result_clamp_fault // R05
         | calibration_range_fault | modulator_saturation; // R06
      raw_events[fault_flag_pkg::bit_ignored] = access_while_ignored; // R07
      raw_events[fault_flag_pkg::bit_clock_count] = count_fault; // R08
   end

   // disabled flags neither set nor hold a new event
   assign set_vec = raw_events & fault_enable
      & fault_flag_pkg::implemented_mask; // R09
   assign clr_vec = status_write ? status_wdata : 16'h0000; // R10

   // ----------------------------------------
   // sticky flags
   // ----------------------------------------
   always_comb
   begin
      // set wins over a same-cycle clear so no event is lost
      nxt_st.flags = ((st_ff.flags & ~clr_vec) | set_vec) // R10 R11
         & fault_flag_pkg::implemented_mask;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_ff.flags <= fault_flag_pkg::status_reset; // R02
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign fault_status_flags = st_ff.flags;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_pos_set;
      @(posedge clk) disable iff (reset)
      pos_input_range_fault && fault_enable[11] |=> fault_status_flags[11];
   endproperty
   a_pos_set: assert property (p_pos_set) else $error("pos flag not set"); // R01

   property p_neg_set;
      @(posedge clk) disable iff (reset)
      neg_input_range_fault && fault_enable[10] |=> fault_status_flags[10];
   endproperty
   a_neg_set: assert property (p_neg_set) else $error("neg flag not set"); // R02

   property p_ref_set;
      @(posedge clk) disable iff (reset)
      reference_range_fault && fault_enable[9] |=> fault_status_flags[9];
   endproperty
   a_ref_set: assert property (p_ref_set) else $error("ref flag not set"); // R03

   property p_low_set;
      @(posedge clk) disable iff (reset)
      reference_low_fault && fault_enable[8] |=> fault_status_flags[8];
   endproperty
   a_low_set: assert property (p_low_set) else $error("low flag not set"); // R04

   property p_clamp_set;
      @(posedge clk) disable iff (reset)
      result_clamp_fault && fault_enable[7] |=> fault_status_flags[7];
   endproperty
   a_clamp_set: assert property (p_clamp_set) else $error("clamp lost"); // R05

   property p_cal_set;
      @(posedge clk) disable iff (reset)
      (calibration_range_fault || modulator_saturation) && fault_enable[7]
      |=> fault_status_flags[7];
   endproperty
   a_cal_set: assert property (p_cal_set) else $error("cal lost"); // R06

   property p_ign_set;
      @(posedge clk) disable iff (reset)
      access_while_ignored && fault_enable[6] |=> fault_status_flags[6];
   endproperty
   a_ign_set: assert property (p_ign_set) else $error("ignore lost"); // R07

   property p_cnt_set;
      @(posedge clk) disable iff (reset)
      frame_active ##1 !frame_active && u_edge_chk.st_ff.cnt != 3'h0
      && fault_enable[5] |=> ##1 fault_status_flags[5];
   endproperty
   a_cnt_set: assert property (p_cnt_set) else $error("count lost"); // R08

   property p_enable_gate;
      @(posedge clk) disable iff (reset)
      !fault_status_flags[11] && !fault_enable[11] |=> !fault_status_flags[11];
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("gated"); // R09

   property p_w1c;
      @(posedge clk) disable iff (reset)
      status_write && status_wdata[10] && !set_vec[10]
      |=> !fault_status_flags[10];
   endproperty
   a_w1c: assert property (p_w1c) else $error("w1c failed"); // R10

   property p_sticky;
      @(posedge clk) disable iff (reset)
      fault_status_flags[9] && !(status_write && status_wdata[9])
      |=> fault_status_flags[9];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped"); // R11

   property p_pos_cause;
      @(posedge clk) disable iff (reset)
      !fault_status_flags[11] && !(pos_input_range_fault && fault_enable[11])
      |=> !fault_status_flags[11];
   endproperty
   a_pos_cause: assert property (p_pos_cause) // R01
      else $error("pos spurious");

   property p_neg_cause;
      @(posedge clk) disable iff (reset)
      !fault_status_flags[10] && !(neg_input_range_fault && fault_enable[10])
      |=> !fault_status_flags[10];
   endproperty
   a_neg_cause: assert property (p_neg_cause) // R02
      else $error("neg spurious");

   // flag 5 has one source only: the frame checker's end-of-frame pulse
   property p_cnt_cause;
      @(posedge clk) disable iff (reset)
      !fault_status_flags[5] && !count_fault |=> !fault_status_flags[5];
   endproperty
   a_cnt_cause: assert property (p_cnt_cause) // R08
      else $error("count spurious");

   property p_set_wins;
      @(posedge clk) disable iff (reset)
      reference_range_fault && fault_enable[9] && status_write
      && status_wdata[9] |=> fault_status_flags[9];
   endproperty
   a_set_wins: assert property (p_set_wins) // R10
      else $error("set lost to clear");

   property p_zero_keeps;
      @(posedge clk) disable iff (reset)
      fault_status_flags[8] && status_write && !status_wdata[8]
      |=> fault_status_flags[8];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) // R10
      else $error("zero write cleared");

   // not disabled by reset: this one watches reset itself
   property p_reset_clear;
      @(posedge clk)
      reset |=> fault_status_flags == fault_flag_pkg::status_reset;
   endproperty
   a_reset_clear: assert property (p_reset_clear) // R02
      else $error("reset left flags");
endmodule
`default_nettype wire

// >>> inc/fault_flag_pkg.sv
// Summary of operation
// (R01) positive input flag set only after a positive input range fault detected
// (R02) bit 10 sets on negative input range fault; zero means none; resets zero
// (R03) bit 9 sets on external reference over or undervoltage
// (R04) bit 8 sets when differential reference falls below threshold
// (R05) bit 7 sets when a result clamps at positive or negative full scale
// (R06) bit 7 also sets on calibration out of range or modulator saturation
// (R07) bit 6 sets when a serial access arrives while accesses are ignored
// (R08) bit 5 sets when frame clock edge count is not a multiple of eight
// (R09) each flag operates only while its enable bit is set
// (R10) writing one clears a flag; writing zero leaves it unchanged
// (R11) a set flag stays set until cleared, even after fault goes away
package fault_flag_pkg;
   localparam int unsigned reg_width = 16;
   // ----------------------------------------
   // field positions of the status register
   // ----------------------------------------
   localparam int unsigned bit_pos_input = 11;
   localparam int unsigned bit_neg_input = 10;
   localparam int unsigned bit_ref_range = 9;
   localparam int unsigned bit_ref_detect = 8;
   localparam int unsigned bit_converter = 7;
   localparam int unsigned bit_ignored = 6;
   localparam int unsigned bit_clock_count = 5;
   localparam logic [15:0] status_reset = 16'h0000;
   // bits 15:12 reserved, 4:0 belong to other blocks: read zero here
   localparam logic [15:0] implemented_mask = 16'h0FE0;
   localparam logic [2:0] frame_bits_mask = 3'h7;
endpackage

// >>> logic/frame_edge_checker.sv
`timescale 1ns/100ps
`default_nettype none
module frame_edge_checker
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial frame events, already in clk domain
   input wire logic frame_active,
   input wire logic clock_edge,
   // result
   output logic count_fault
);
   typedef struct packed
   {
      logic [2:0] cnt;
      logic active;
      logic fault;
   } chk_state_t;

   chk_state_t st_ff;
   chk_state_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.fault = 1'b0;
      if (frame_active && clock_edge)
      begin
         nxt_st.cnt = st_ff.cnt + 3'h1;
      end
      // frame end: a partial byte means a miscounted transfer
      if (st_ff.active && !frame_active)
      begin
         nxt_st.fault = ((st_ff.cnt & fault_flag_pkg::frame_bits_mask)
                         != 3'h0); // R08
         nxt_st.cnt = 3'h0;
      end
      nxt_st.active = frame_active;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign count_fault = st_ff.fault;
endmodule
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   // clock
   input wire logic clk,
   // register writes and serial frames
   output logic status_write,
   output logic [15:0] status_wdata,
   output logic frame_active,
   output logic frame_clock_edge
);
   initial
   begin
      status_write = 1'b0;
      status_wdata = 16'h0000;
      frame_active = 1'b0;
      frame_clock_edge = 1'b0;
   end
   // data goes to its inverse after the strobe so stale ones never match
   task automatic wr(input logic [15:0] d);
      @(negedge clk);
      status_write <= 1'b1;
      status_wdata <= d;
      @(negedge clk);
      status_write <= 1'b0;
      status_wdata <= ~d;
   endtask
   task automatic frame(input int n);
      @(negedge clk);
      frame_active <= 1'b1;
      repeat (n)
      begin
         @(negedge clk);
         frame_clock_edge <= 1'b1;
         @(negedge clk);
         frame_clock_edge <= 1'b0;
      end
      @(negedge clk);
      frame_active <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/fault_flag_status_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fault_flag_status_bank_tb;
   logic clk;
   logic reset;
   logic [7:0] flt;
   logic [15:0] en;
   logic sw, fa, fe;
   logic [15:0] wd, flags;
   int n_errors = 0;
   int samples_checked = 0;
   int pos [8] = '{11, 10, 9, 8, 7, 7, 7, 6};
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   fault_flag_status_bank dut (.clk(clk), .reset(reset),
      .pos_input_range_fault(flt[0]), .neg_input_range_fault(flt[1]),
      .reference_range_fault(flt[2]), .reference_low_fault(flt[3]),
      .result_clamp_fault(flt[4]), .calibration_range_fault(flt[5]),
      .modulator_saturation(flt[6]), .access_while_ignored(flt[7]),
      .frame_active(fa), .frame_clock_edge(fe), .fault_enable(en),
      .status_write(sw), .status_wdata(wd), .fault_status_flags(flags));
   host_model h (.clk(clk), .status_write(sw), .status_wdata(wd),
      .frame_active(fa), .frame_clock_edge(fe));
   task automatic chk(input logic [15:0] exp);
      samples_checked++;
      if (flags !== exp)
      begin
         n_errors++;
         $display("ERROR %0t exp %h got %h", $time, exp, flags);
      end
   endtask
   task automatic results;
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask
   // one-cycle pulses only: the flag must outlive its cause
   task automatic t_events;
      logic [15:0] b;
      for (int i = 0; i < 8; i++)
      begin
         b = 16'(32'h1 << pos[i]);
         @(negedge clk);
         flt <= 8'(32'h1 << i);
         @(negedge clk);
         flt <= 8'h00;
         settle();
         chk(b);
         h.wr(~b);
         settle();
         chk(b);
         h.wr(b);
         settle();
         chk(16'h0000);
      end
   endtask
   task automatic t_disabled;
      @(negedge clk);
      en <= 16'h0000;
      flt <= 8'hFF;
      h.frame(3);
      flt <= 8'h00;
      settle();
      chk(16'h0000);
      @(negedge clk);
      en <= 16'h0400;
      flt <= 8'hFF;
      @(negedge clk);
      flt <= 8'h00;
      settle();
      chk(16'h0400);
      h.wr(16'hFFFF);
      settle();
      chk(16'h0000);
      en <= 16'hFFFF;
   endtask
   // event and clear in one cycle: the event must win
   task automatic t_collide;
      fork
         h.wr(16'h0200);
         begin
            @(negedge clk);
            flt <= 8'h04;
            @(negedge clk);
            flt <= 8'h00;
         end
      join
      settle();
      chk(16'h0200);
      h.wr(16'h0200);
      settle();
      chk(16'h0000);
   endtask
   task automatic t_frames;
      h.frame(7);
      settle();
      chk(16'h0020);
      h.wr(16'h0020);
      h.frame(8);
      settle();
      chk(16'h0000);
      h.frame(9);
      settle();
      chk(16'h0020);
      reset <= 1'b1;
      settle();
      reset <= 1'b0;
      settle();
      chk(16'h0000);
   endtask
   initial
   begin
      reset = 1'b1;
      flt = 8'h00;
      en = 16'hFFFF;
      repeat (2) @(negedge clk);
      reset <= 1'b0;
      settle();
      chk(16'h0000);
      t_events();
      t_collide();
      t_disabled();
      t_frames();
      results();
   end
endmodule
`default_nettype wire
